// ==== inc/airc_regs.svh ====
// Constants for the inverse round and carry-less multiply datapath
`ifndef AIRC_REGS_SVH
`define AIRC_REGS_SVH

// Cycles from an accepted operand strobe to the result strobe
`define AIRC_LATENCY       2
// Feature query leaf and the bit positions it reports in its ECX word
`define AIRC_FEAT_LEAF     32'h0000_0001
`define AIRC_FEAT_BC_BIT   25
`define AIRC_FEAT_CLMUL_BIT 1
// Low byte of the field polynomial x^8 + x^4 + x^3 + x + 1
`define AIRC_FF_POLY       8'h1B

`endif

// ==== inc/airc_pkg.sv ====
// Types shared by the inverse round and carry-less multiply datapath
`default_nettype none
package airc_pkg;

   // Operation selector carried with each operand strobe
   typedef enum logic [2:0] {
      OP_WORD_SUB = 3'h0,
      OP_INV_MIX  = 3'h1,
      OP_INV_ROT  = 3'h2,
      OP_INV_SUB  = 3'h3,
      OP_CLMUL    = 3'h4
   } airc_op_t;

   // Whole module state: operand stage, result stage, feature word
   typedef struct packed {
      logic           s1_valid;
      airc_op_t       s1_op;
      logic [127:0]   s1_a;
      logic [63:0]    s1_b;
      logic           out_valid;
      logic [127:0]   out_result;
      logic [31:0]    feat_ecx;
   } airc_state_t;

endpackage
`default_nettype wire

// ==== inc/airc_clmul_if.sv ====
// Operand and product wires between the datapath and its multiplier
`default_nettype none
interface airc_clmul_if;
   logic [63:0]  a;
   logic [63:0]  b;
   logic [127:0] p;
   modport client (output a, output b, input p);
   modport unit   (input a, input b, output p);
endinterface
`default_nettype wire

// ==== design/airc_clmul.sv ====
// 64 by 64 carry-less multiplier, purely combinational
`default_nettype none
module airc_clmul (
   // Operands in, product out
   airc_clmul_if.unit m
);
   // ==================================================================
   // Partial product accumulation
   // ==================================================================
   // XOR of shifted copies, no carries ever propagate
   always_comb begin
      logic [127:0] acc;
      acc = 128'h0;
      for (int i = 0; i < 64; i++) begin
         if (m.b[i]) begin
            acc = acc ^ ({64'h0, m.a} << i);
         end
      end
      m.p = acc;
   end
endmodule // airc_clmul
`default_nettype wire

// ==== design/airc_top.sv ====
// Inverse round transforms, word substitution and carry-less multiply
`include "airc_regs.svh"
`default_nettype none

// Summary of operation
// - Word substitution maps each byte of the low word in place
// - Mixed row 0 uses 0E 0B 0D 09
// - Mixed row 1 uses 09 0E 0B 0D
// - Rows 2, 3 use rotated coefficient sets
// - Rotate rows 1..3 right by 1..3
// - Inverse table indexed by upper, lower nibble
// - Carry-less 64x64 multiply, full 128-bit product
// - Feature bit 25 of leaf 01H
// - Multiplier feature bit 1 of leaf 01H
// - Field multiply reduced by x^8+x^4+x^3+x+1
// - Forward table is fixed 256-entry mapping
module airc_top
   import airc_pkg::*;
(
   // Clock and reset
   input  wire  logic         i_clk,
   input  wire  logic         i_rst,
   // Operand bus from the pipeline
   input  wire  logic         i_valid,
   input  var   airc_op_t     i_op,
   input  wire  logic [127:0] i_a,
   input  wire  logic [63:0]  i_b,
   // Feature query
   input  wire  logic [31:0]  i_query_leaf,
   // Result bus and feature report
   output logic               o_valid,
   output logic [127:0]       o_result,
   output logic [31:0]        o_feat_ecx
);

   // ==================================================================
   // Substitution tables
   // ==================================================================
   // Forward table, entry 0 first; row index is the upper nibble
   localparam logic [0:255][7:0] FWD_TABLE = {
      256'h637C777BF26B6FC53001672BFED7AB76CA82C97DFA5947F0ADD4A2AF9CA472C0,
      256'hB7FD9326363FF7CC34A5E5F171D8311504C723C31896059A071280E2EB27B275,
      256'h09832C1A1B6E5AA0523BD6B329E32F8453D100ED20FCB15B6ACBBE394A4C58CF,
      256'hD0EFAAFB434D338545F9027F503C9FA851A3408F929D38F5BCB6DA2110FFF3D2,
      256'hCD0C13EC5F974417C4A77E3D645D197360814FDC222A908846EEB814DE5E0BDB,
      256'hE0323A0A4906245CC2D3AC629195E479E7C8376D8DD54EA96C56F4EA657AAE08,
      256'hBA78252E1CA6B4C6E8DD741F4BBD8B8A703EB5664803F60E613557B986C11D9E,
      256'hE1F8981169D98E949B1E87E9CE5528DF8CA1890DBFE6426841992D0FB054BB16
   };

   // Built as the exact inverse permutation so the two cannot disagree
   function automatic logic [0:255][7:0] build_inverse();
      logic [0:255][7:0] t;
      t = '0;
      for (int i = 0; i < 256; i++) begin
         t[FWD_TABLE[i]] = 8'(i);
      end
      return t;
   endfunction

   localparam logic [0:255][7:0] INV_TABLE = build_inverse();

   // ==================================================================
   // Byte arithmetic
   // ==================================================================
   // Shift-and-add over GF(2^8), reducing after every doubling
   function automatic logic [7:0] field_multiply(input logic [7:0] c,
                                                 input logic [7:0] v);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = v;
      for (int k = 0; k < 8; k++) begin
         if (c[k]) begin
            p = p ^ x;
         end
         x = x[7] ? ((x << 1) ^ `AIRC_FF_POLY) : (x << 1);
      end
      return p;
   endfunction

   // State byte S(r,c) sits at byte 4c+r of the 128-bit word
   function automatic logic [7:0] st(input logic [127:0] s,
                                     input int r, input int c);
      return s[(4 * c + r) * 8 +: 8];
   endfunction

   function automatic logic [127:0] word_substitution(
         input logic [127:0] s);
      logic [127:0] o;
      o = 128'h0;
      for (int k = 0; k < 4; k++) begin
         o[k * 8 +: 8] = FWD_TABLE[s[k * 8 +: 8]];
      end
      return o;
   endfunction

   function automatic logic [127:0] inverse_byte_substitution(
         input logic [127:0] s);
      logic [127:0] o;
      o = 128'h0;
      for (int k = 0; k < 16; k++) begin
         o[k * 8 +: 8] = INV_TABLE[{s[k * 8 + 4 +: 4], s[k * 8 +: 4]}];
      end
      return o;
   endfunction

   function automatic logic [127:0] inverse_row_rotation(
         input logic [127:0] s);
      logic [127:0] o;
      o = 128'h0;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            o[(4 * c + r) * 8 +: 8] = st(s, r, (c + 4 - r) % 4);
         end
      end
      return o;
   endfunction

   // One output row: coefficients rotate right by one per row
   function automatic logic [127:0] inverse_column_mixing(
         input logic [127:0] s);
      logic [127:0]      o;
      logic [0:3][7:0]   k;
      o = 128'h0;
      k = {8'h0E, 8'h0B, 8'h0D, 8'h09};
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            o[(4 * c + r) * 8 +: 8] =
               field_multiply(k[(4 - r) % 4], st(s, 0, c)) ^
               field_multiply(k[(5 - r) % 4], st(s, 1, c)) ^
               field_multiply(k[(6 - r) % 4], st(s, 2, c)) ^
               field_multiply(k[(7 - r) % 4], st(s, 3, c));
         end
      end
      return o;
   endfunction

   // ==================================================================
   // Multiplier
   // ==================================================================
   airc_clmul_if mul_if ();

   airc_clmul airc_clmul_i (
      .m (mul_if.unit)
   );

   airc_state_t state_r;
   airc_state_t state_nxt;

   // Multiplier sees the registered operands, so stage 2 holds no loop
   assign mul_if.a = state_r.s1_a[63:0];
   assign mul_if.b = state_r.s1_b;

   // ==================================================================
   // Pipeline
   // ==================================================================
   // Stage 1 captures operands, stage 2 registers the selected result;
   // operand and result registers keep their values while no strobe arrives
   always_comb begin
      state_nxt           = state_r;
      state_nxt.s1_valid  = i_valid;
      state_nxt.out_valid = state_r.s1_valid;
      if (i_valid) begin
         state_nxt.s1_op = i_op;
         state_nxt.s1_a  = i_a;
         state_nxt.s1_b  = i_b;
      end
      if (state_r.s1_valid) begin
         unique case (state_r.s1_op)
            OP_WORD_SUB: state_nxt.out_result =
                            word_substitution(state_r.s1_a);
            OP_INV_MIX:  state_nxt.out_result =
                            inverse_column_mixing(state_r.s1_a);
            OP_INV_ROT:  state_nxt.out_result =
                            inverse_row_rotation(state_r.s1_a);
            OP_INV_SUB:  state_nxt.out_result =
                            inverse_byte_substitution(state_r.s1_a);
            OP_CLMUL:    state_nxt.out_result = mul_if.p;
            default:     state_nxt.out_result = 128'h0; // Undefined selector
         endcase
      end
      // Feature word answers one cycle after the leaf is presented
      state_nxt.feat_ecx = 32'h0;
      if (i_query_leaf == `AIRC_FEAT_LEAF) begin
         state_nxt.feat_ecx[`AIRC_FEAT_BC_BIT]    = 1'b1;
         state_nxt.feat_ecx[`AIRC_FEAT_CLMUL_BIT] = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign o_valid    = state_r.out_valid;
   assign o_result   = state_r.out_result;
   assign o_feat_ecx = state_r.feat_ecx;

   // ==================================================================
   // Assertions
   // ==================================================================
   sequence s_issue(airc_op_t op);
      i_valid && i_op == op;
   endsequence

   sequence s_done;
      ##2 o_valid;
   endsequence

   a_valid_latency: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_valid |-> s_done and (##1 1'b1))
      else $error("result strobe not two cycles after operands");
   a_no_spurious: assert property (@(posedge i_clk) disable iff (i_rst)
      o_valid |-> $past(i_valid, 2))
      else $error("result strobe without operands");
   // Each byte looked up on its own, so a swapped lane shows
   a_word_subst: assert property (@(posedge i_clk) disable iff (i_rst)
      s_issue(OP_WORD_SUB) |-> s_done ##0 (o_result[31:0] ==
      {FWD_TABLE[$past(i_a[31:24], 2)], FWD_TABLE[$past(i_a[23:16], 2)],
       FWD_TABLE[$past(i_a[15:8], 2)], FWD_TABLE[$past(i_a[7:0], 2)]}))
      else $error("word substitution wrong");
   a_mix_row0: assert property (@(posedge i_clk) disable iff (i_rst)
      s_issue(OP_INV_MIX) |-> s_done ##0 (o_result[7:0] ==
      (field_multiply(8'h0E, $past(i_a[7:0], 2)) ^
       field_multiply(8'h0B, $past(i_a[15:8], 2)) ^
       field_multiply(8'h0D, $past(i_a[23:16], 2)) ^
       field_multiply(8'h09, $past(i_a[31:24], 2)))))
      else $error("mixed row 0 wrong");
   a_mix_row1: assert property (@(posedge i_clk) disable iff (i_rst)
      s_issue(OP_INV_MIX) |-> s_done ##0 (o_result[15:8] ==
      (field_multiply(8'h09, $past(i_a[7:0], 2)) ^
       field_multiply(8'h0E, $past(i_a[15:8], 2)) ^
       field_multiply(8'h0B, $past(i_a[23:16], 2)) ^
       field_multiply(8'h0D, $past(i_a[31:24], 2)))))
      else $error("mixed row 1 wrong");
   a_mix_row3: assert property (@(posedge i_clk) disable iff (i_rst)
      s_issue(OP_INV_MIX) |-> s_done ##0 (o_result[127:120] ==
      (field_multiply(8'h0B, $past(i_a[103:96], 2)) ^
       field_multiply(8'h0D, $past(i_a[111:104], 2)) ^
       field_multiply(8'h09, $past(i_a[119:112], 2)) ^
       field_multiply(8'h0E, $past(i_a[127:120], 2)))))
      else $error("mixed row 3 wrong");
   a_row_rotate: assert property (@(posedge i_clk) disable iff (i_rst)
      s_issue(OP_INV_ROT) |-> s_done ##0
      (o_result[15:8] == $past(i_a[111:104], 2) &&
       o_result[7:0] == $past(i_a[7:0], 2)))
      else $error("row rotation wrong");
   a_inv_subst: assert property (@(posedge i_clk) disable iff (i_rst)
      s_issue(OP_INV_SUB) |-> s_done ##0
      (FWD_TABLE[o_result[7:0]] == $past(i_a[7:0], 2)))
      else $error("inverse substitution wrong");
   // Top byte of the result mapped forward must give the operand back
   a_table_roundtrip: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_issue(OP_INV_SUB) |-> s_done ##0
      (FWD_TABLE[o_result[127:120]] == $past(i_a[127:120], 2)))
      else $error("tables do not invert");
   a_clmul_unit: assert property (@(posedge i_clk) disable iff (i_rst)
      (s_issue(OP_CLMUL) ##0 (i_b == 64'h1)) |-> s_done ##0
      (o_result == {64'h0, $past(i_a[63:0], 2)}))
      else $error("carry-less product wrong");
   a_feat_bits: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_query_leaf == `AIRC_FEAT_LEAF) |=>
      (o_feat_ecx[`AIRC_FEAT_BC_BIT] && o_feat_ecx[`AIRC_FEAT_CLMUL_BIT]))
      else $error("feature bits missing");

endmodule // airc_top
`default_nettype wire

// ==== bench/airc_pipe_model.sv ====
// Pipeline-side operand driver and result collector for the datapath
`default_nettype none
module airc_pipe_model
   import airc_pkg::*;
(
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // Results from the datapath
   input  wire logic         i_res_valid,
   input  wire logic [127:0] i_res,
   // Operands to the datapath
   output var  logic         o_valid,
   output var  airc_op_t     o_op,
   output var  logic [127:0] o_a,
   output var  logic [63:0]  o_b
);
   timeunit 1ns;
   timeprecision 1ns;
   int           cyc = 0;
   int           take_q[$];
   int           res_cyc_q[$];
   logic [127:0] res_q[$];

   initial begin
      o_valid = 1'b0;
      o_op = OP_WORD_SUB;
      o_a = 128'h0;
      o_b = 64'h0;
   end

   // Log the edge of every taken operand and every result
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (!i_rst && o_valid) take_q.push_back(cyc);
      if (i_res_valid) begin
         res_cyc_q.push_back(cyc);
         res_q.push_back(i_res);
      end
   end

   // One operand set; strobe stays up when the next call follows at once
   task automatic send(input airc_op_t op, input logic [127:0] a,
                       input logic [63:0] b);
      @(negedge i_clk);
      o_valid = 1'b1;
      o_op = op;
      o_a = a;
      o_b = b;
   endtask

   // Drop the strobe; operands flip so stale data never passes for fresh
   task automatic idle();
      @(negedge i_clk);
      o_valid = 1'b0;
      o_a = ~o_a;
      o_b = ~o_b;
   endtask
endmodule // airc_pipe_model
`default_nettype wire

// ==== bench/airc_top_tb.sv ====
// Self-checking bench for the inverse round and carry-less datapath
`include "airc_regs.svh"
`default_nettype none
module airc_top_tb;
   import airc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, valid, res_valid;
   airc_op_t op;
   logic [127:0] a, res;
   logic [63:0] b;
   logic [31:0] leaf, feat;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;

   airc_top airc_top_i (.i_clk(clk), .i_rst(rst), .i_valid(valid),
      .i_op(op), .i_a(a), .i_b(b), .i_query_leaf(leaf),
      .o_valid(res_valid), .o_result(res), .o_feat_ecx(feat));
   airc_pipe_model airc_pipe_model_i (.i_clk(clk), .i_rst(rst),
      .i_res_valid(res_valid), .i_res(res), .o_valid(valid), .o_op(op),
      .o_a(a), .o_b(b));

   // ==================================================================
   // Reference arithmetic, built from the field rules alone
   function automatic logic [7:0] fmul(logic [7:0] x, logic [7:0] y);
      logic [7:0] p;
      p = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (y[i]) p ^= x;
         x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
      end
      return p;
   endfunction
   // Forward table as inverse-then-affine; slow but needs no table
   function automatic logic [7:0] sbox(logic [7:0] x);
      logic [7:0] v;
      v = 8'h01;
      for (int i = 0; i < 254; i++) v = fmul(v, x);
      return v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]}
         ^ {v[3:0], v[7:4]} ^ 8'h63;
   endfunction
   function automatic logic [255:0] clm(logic [127:0] x, logic [127:0] y);
      logic [255:0] p;
      p = 256'h0;
      for (int i = 0; i < 128; i++) if (y[i]) p ^= {128'h0, x} << i;
      return p;
   endfunction

   // ==================================================================
   // Comparison, result collection and verdict
   task automatic check(input string what, input logic [255:0] seen,
                        input logic [255:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic pop(output logic [127:0] r);
      int n;
      n = 0;
      r = 128'h0;
      while (airc_pipe_model_i.res_q.size() == 0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      check("result", 256'(n < 20), 256'h1);
      if (n < 20) begin
         r = airc_pipe_model_i.res_q.pop_front();
         check("latency", 256'(airc_pipe_model_i.res_cyc_q.pop_front()
            - airc_pipe_model_i.take_q.pop_front()),
            256'(`AIRC_LATENCY));
      end
   endtask
   task automatic results();
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ==================================================================
   // Scenarios
   task automatic t_word_sub();
      logic [127:0] r;
      airc_pipe_model_i.send(OP_WORD_SUB, {96'h0, 32'h0053_FF10}, 64'h0);
      airc_pipe_model_i.idle();
      pop(r);
      check("word sub", r[31:0], 32'h63ED_16CA);
   endtask
   task automatic t_inv_mix();
      logic [7:0] k0 [4] = '{8'h0E, 8'h0B, 8'h0D, 8'h09};
      logic [127:0] s [2] = '{128'hDB13_5345_F20A_225C_0123_4567_89AB_CDEF,
                              {128{1'b1}}};
      logic [127:0] r, e;
      foreach (s[i]) airc_pipe_model_i.send(OP_INV_MIX, s[i], 64'h0);
      airc_pipe_model_i.idle();
      foreach (s[i]) begin
         e = 128'h0;
         for (int c = 0; c < 4; c++)
            for (int w = 0; w < 4; w++)
               for (int k = 0; k < 4; k++)
                  e[32*c+8*w +: 8] ^= fmul(k0[(k-w)&3], s[i][32*c+8*k +: 8]);
         pop(r);
         check("inverse mix", r, e);
      end
   endtask
   task automatic t_inv_rot();
      logic [127:0] r, e;
      for (int i = 0; i < 16; i++) e[8*i +: 8] = 8'(4*(((i/4)-(i%4))&3) + i%4);
      airc_pipe_model_i.send(OP_INV_ROT,
         128'h0F0E_0D0C_0B0A_0908_0706_0504_0302_0100, 64'h0);
      airc_pipe_model_i.idle();
      pop(r);
      check("inverse rotate", r, e);
   endtask
   // All 256 byte values back to back, each result mapped forward again
   task automatic t_inv_sub();
      logic [127:0] r, f, s;
      for (int k = 0; k < 16; k++) begin
         for (int j = 0; j < 16; j++) s[8*j +: 8] = 8'(16*k + j);
         airc_pipe_model_i.send(OP_INV_SUB, s, 64'h0);
      end
      airc_pipe_model_i.idle();
      for (int k = 0; k < 16; k++) begin
         pop(r);
         for (int j = 0; j < 16; j++) begin
            f[8*j +: 8] = sbox(r[8*j +: 8]);
            s[8*j +: 8] = 8'(16*k + j);
         end
         check("inverse sub", f, s);
         if (k == 0) check("inverse of 00", r[7:0], 8'h52);
         if (k == 15) check("inverse of FF", r[127:120], 8'h7D);
      end
   endtask
   // Wide product assembled from four narrow products
   task automatic t_clmul();
      logic [127:0] x, y, u, p [4];
      logic [255:0] w;
      x = 128'hFFFF_FFFF_FFFF_FFFF_8000_0000_0000_0001;
      y = 128'h0123_4567_89AB_CDEF_FFFF_FFFF_FFFF_FFFF;
      for (int i = 0; i < 4; i++)
         airc_pipe_model_i.send(OP_CLMUL, {64'h0, x[64*(i/2) +: 64]},
            y[64*(i%2) +: 64]);
      // Times one: upper operand half must be ignored
      airc_pipe_model_i.send(OP_CLMUL, x, 64'h1);
      airc_pipe_model_i.idle();
      foreach (p[i]) pop(p[i]);
      pop(u);
      w = {128'h0, p[0]} ^ ({128'h0, p[1] ^ p[2]} << 64) ^ {p[3], 128'h0};
      check("carry-less", w, clm(x, y));
      check("carry-less by one", u, {64'h0, x[63:0]});
   endtask
   // An undefined operation code must come back as zero
   task automatic t_bad_op();
      logic [127:0] r;
      airc_pipe_model_i.send(airc_op_t'(3'h5), {128{1'b1}}, {64{1'b1}});
      airc_pipe_model_i.idle();
      pop(r);
      check("undefined op", r, 128'h0);
   endtask
   task automatic t_feature();
      @(negedge clk);
      leaf = 32'h1;
      @(negedge clk);
      check("feature word", feat, 32'h0200_0002);
      leaf = 32'h2;
      @(negedge clk);
      check("feature other leaf", feat, 32'h0);
   endtask

   // ==================================================================
   // Clock, hang guard and main sequence
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      rst = 1'b1;
      leaf = 32'h0;
      repeat (10) @(negedge clk);
      check("reset outputs", {res_valid, res, feat}, 256'h0);
      rst = 1'b0;
      t_word_sub();
      t_inv_mix();
      t_inv_rot();
      t_inv_sub();
      t_clmul();
      t_bad_op();
      t_feature();
      repeat (4) @(negedge clk);
      check("extra results", airc_pipe_model_i.res_q.size(), 256'h0);
      results();
   end
endmodule // airc_top_tb
`default_nettype wire
